/* File: bench/cfg_decoder_properties.sv */
// Purpose: port properties of the config decoder
// Assumes: one clock, async active-low reset
// Notes: load edge seen from the bus; window of two cycles for the update
`timescale 1ns/1ps
`include "cfg_loader_regs.svh"
`default_nettype none

module cfg_decoder_properties (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic hsel_i,
  input wire logic [7:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  input wire logic [5:0] gpio_out_o,
  input wire logic [5:0] gpio_oe_o,
  input wire logic [5:0] system_interrupt_report_o,
  input wire logic search_done_i,
  input wire logic [1:0] units_found_i,
  input wire logic search_request_o,
  input wire logic drive_access_ok_o,
  input wire logic [1:0] units_present_o,
  input wire cfg_loader_pkg::drive_cfg_type drive_cfg_o
);
  import cfg_loader_pkg::*;
  // ****************
  // load tracking
  // ****************
  logic ctrl_wr_ff;
  logic load_ff;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_wr_ff <= 1'b0;
      load_ff <= 1'b0;
    end else begin
      ctrl_wr_ff <= hsel_i & htrans_i[1] & hready_i & hwrite_i & (haddr_i[7:2] == `IDX_CONTROL);
      load_ff <= ctrl_wr_ff & hwdata_i[`CTRL_LOAD];
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);
  sequence s_search;
    search_request_o ##[1:40] search_done_i;
  endsequence
  chk_out_masked: assert property ((gpio_out_o & ~gpio_oe_o) == 6'h00)
    else $error("level on an input pin");
  chk_report_masked: assert property (
    (system_interrupt_report_o & gpio_oe_o & $past(gpio_oe_o)) == 6'h00)
    else $error("output pin reported");
  chk_found_latch: assert property (s_search |=> units_present_o == $past(units_found_i))
    else $error("units not latched");
  chk_search_pulse: assert property (search_request_o |=> !search_request_o)
    else $error("search request too long");
  chk_search_late: assert property (search_request_o |-> drive_access_ok_o)
    else $error("search before delay end");
  chk_cfg_on_load: assert property ($changed(drive_cfg_o) |-> load_ff || $past(load_ff))
    else $error("config changed without load");
  chk_pins_on_load: assert property (
    $changed({gpio_oe_o, gpio_out_o}) |-> $past(load_ff) || $past(load_ff, 2))
    else $error("pins changed without load");
  chk_name_select: assert property (load_ff |=>
    drive_cfg_o.unit0_use_drive_id == (drive_cfg_o.unit0_ptr == 8'h00) &&
    drive_cfg_o.unit1_use_drive_id == (drive_cfg_o.unit1_ptr == 8'h00))
    else $error("name pointer select wrong");
  chk_removable: assert property (load_ff |=>
    drive_cfg_o.unit0_removable == (drive_cfg_o.power_valid_en && !drive_cfg_o.bus_powered))
    else $error("removable flag wrong");
endmodule

bind storage_bridge_config_decoder cfg_decoder_properties i_chk (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
  .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i), .hready_i(hready_i),
  .gpio_out_o(gpio_out_o), .gpio_oe_o(gpio_oe_o),
  .system_interrupt_report_o(system_interrupt_report_o), .search_done_i(search_done_i),
  .units_found_i(units_found_i), .search_request_o(search_request_o),
  .drive_access_ok_o(drive_access_ok_o), .units_present_o(units_present_o),
  .drive_cfg_o(drive_cfg_o)
);
`default_nettype wire

/* File: bench/drive_engine_model.sv */
// Purpose: drive engine that answers search requests
// Assumes: request is a one-cycle pulse
// Notes: unit lines carry junk outside the done cycle
`timescale 1ns/1ps
`default_nettype none

module drive_engine_model (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic search_request_i,
  input wire logic [1:0] units_i,
  input wire logic [3:0] wait_i,
  output logic search_done_o,
  output logic [1:0] units_found_o
);
  // ****************
  // search answer
  // ****************
  logic busy_ff;
  logic [3:0] cnt_ff;
  logic [1:0] junk_ff;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      busy_ff <= 1'b0;
      cnt_ff <= 4'h0;
      junk_ff <= 2'h1;
      search_done_o <= 1'b0;
    end else begin
      junk_ff <= ~junk_ff;
      search_done_o <= 1'b0;
      if (search_request_i) begin
        busy_ff <= 1'b1;
        cnt_ff <= wait_i;
      end else if (busy_ff && cnt_ff != 4'h0) begin
        cnt_ff <= cnt_ff - 4'h1;
      end else if (busy_ff) begin
        busy_ff <= 1'b0;
        search_done_o <= 1'b1;
      end
    end
  end
  // a held value would hide a design that samples the units late
  assign units_found_o = search_done_o ? units_i : junk_ff;
endmodule
`default_nettype wire

/* File: bench/tb_top.sv */
// Purpose: self-checking bench for the config decoder
// Assumes: tick shortened to 10 clocks
// Notes: random image from a fixed seed
`timescale 1ns/1ps
`include "cfg_loader_regs.svh"
`default_nettype none

module tb_top;
  import cfg_loader_pkg::*;
  // ****************
  // signals
  // ****************
  localparam int TICK = 10;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic hsel_i = 1'b0;
  logic [7:0] haddr_i = 8'h00;
  logic [1:0] htrans_i = 2'h0;
  logic hwrite_i = 1'b0;
  logic [31:0] hwdata_i = 32'h0;
  logic [5:0] gpio_in_i = 6'h00;
  logic hpe = 1'b0;
  logic [1:0] units = 2'h0;
  logic [3:0] wait_cnt = 4'h0;
  logic [31:0] hrdata;
  logic [31:0] rd_cap;
  logic hready;
  logic hresp;
  logic [5:0] gpio_out;
  logic [5:0] gpio_oe;
  logic [5:0] rpt;
  logic sreq;
  logic aok;
  logic [1:0] upres;
  logic desc_ok;
  logic sdone;
  logic [1:0] sfound;
  drive_cfg_type cfg;
  logic [7:0] img [18];
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;
  int n_req = 0;

  storage_bridge_config_decoder #(.TICK_CYCLES(TICK)) i_dut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i),
    .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .gpio_in_i(gpio_in_i), .gpio_out_o(gpio_out), .gpio_oe_o(gpio_oe),
    .host_power_drive_enable_i(hpe), .search_done_i(sdone), .units_found_i(sfound),
    .system_interrupt_report_o(rpt), .search_request_o(sreq), .drive_access_ok_o(aok),
    .units_present_o(upres), .desc_ok_o(desc_ok), .drive_cfg_o(cfg)
  );
  drive_engine_model i_drv (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .search_request_i(sreq), .units_i(units),
    .wait_i(wait_cnt), .search_done_o(sdone), .units_found_o(sfound)
  );

  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    rd_cap <= hrdata;
    cycles <= cycles + 1;
    if (sreq === 1'b1) n_req <= n_req + 1;
    if (cycles == 6000) begin
      mismatches = mismatches + 1;
      stop_test();
    end
  end

  // ****************
  // tasks
  // ****************
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic ahb(input logic wr, input logic [5:0] idx, input logic [7:0] wd,
                     output logic [31:0] rd);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    hwrite_i <= wr;
    haddr_i <= {idx, 2'h0};
    do @(posedge clk_i); while (hready !== 1'b1);
    htrans_i <= 2'h0;
    hwdata_i <= {24'h0, wd};
    do @(posedge clk_i); while (hready !== 1'b1);
    #1;
    rd = rd_cap;
    chk("bus response", 32'h0, {31'h0, hresp});
  endtask
  task automatic do_reset();
    rst_b_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  function automatic logic [7:0] mask_of(input logic [5:0] i);
    case (i)
      `IDX_OPTIONS: return 8'h01;
      `IDX_GPIO_DIR, `IDX_GPIO_LVL: return 8'h3F;
      `IDX_DRIVE_OPT: return 8'h1F;
      `IDX_RESERVED: return 8'h00;
      default: return 8'hFF;
    endcase
  endfunction
  function automatic drive_cfg_type exp_cfg(input logic [7:0] o, d, p0, p1);
    return '{o[0], d[4], o[0] & ~d[4], d[3], ~d[0], p0 == 8'h00, p1 == 8'h00, p0, p1};
  endfunction

  // ****************
  // tests
  // ****************
  initial begin
    logic [31:0] r;
    logic [7:0] v;
    int n;
    int base;
    drive_cfg_type ec;
    void'($urandom(32'h3B03A49D));
    do_reset();
    for (int i = 8; i < 18; i++) begin
      ahb(1'b0, 6'(i), 8'h00, r);
      chk("reset value", {24'h0, `RST_BYTE}, r);
    end
    ahb(1'b0, `IDX_CONTROL, 8'h00, r);
    chk("control read", 32'h0, r);
    ahb(1'b0, 6'h3F, 8'h00, r);
    chk("unmapped read", 32'h0, r);
    for (int i = 8; i < 18; i++) begin
      v = 8'($urandom);
      ahb(1'b1, 6'(i), v, r);
      ahb(1'b0, 6'(i), 8'h00, r);
      chk("readback", {24'h0, v & mask_of(6'(i))}, r);
    end
    $display("test registers done");
    // reset before each load so the delay count starts from idle
    for (int k = 0; k < 8; k++) begin
      do_reset();
      img[8] = 8'($urandom) & 8'h01;
      img[9] = 8'($urandom) & 8'h3F;
      img[10] = 8'($urandom) & 8'h3F;
      img[11] = (k == 1) ? 8'h00 : 8'($urandom);
      img[12] = (k == 2) ? 8'h00 : 8'($urandom);
      img[13] = 8'(k % 4);
      img[14] = {3'h0, 2'($urandom), 2'(k / 2), 1'(k % 2)};
      img[15] = 8'h00;
      img[16] = (k % 3 != 0) ? `DESC_LEN_EXPECT : 8'($urandom);
      img[17] = (k % 3 == 1) ? 8'($urandom) : `DESC_TYPE_EXPECT;
      for (int i = 8; i < 18; i++) ahb(1'b1, 6'(i), img[i], r);
      chk("oe before load", 32'h0, {26'h0, gpio_oe});
      units <= 2'($urandom);
      wait_cnt <= 4'($urandom);
      ahb(1'b1, `IDX_CONTROL, 8'h01, r);
      base = n_req;
      n = 0;
      while (aok !== 1'b1 && n < 100) begin
        @(posedge clk_i);
        #1;
        n++;
      end
      chk("startup delay", 32'h1, {31'h0, n >= TICK * (k % 4) && n <= TICK * (k % 4) + 3});
      repeat (24) @(posedge clk_i);
      #1;
      v = {6'h0, (k / 2 == 0) ? units : (k / 2 == 1) ? 2'h1 : 2'h3};
      chk("units present", {24'h0, v}, {30'h0, upres});
      ahb(1'b0, `IDX_STATUS, 8'h00, r);
      chk("status", {25'h0, 1'b1, v[1:0], 4'h4}, {25'h0, r[6:0]});
      chk("search count", 32'(base + (k / 2 == 0)), 32'(n_req));
      ec = exp_cfg(img[8], img[14], img[11], img[12]);
      chk("drive config", 32'(ec), 32'(cfg));
      v = {7'h0, img[16] == `DESC_LEN_EXPECT && img[17] == `DESC_TYPE_EXPECT};
      chk("desc check", {24'h0, v}, {31'h0, desc_ok});
      chk("pin enables", {26'h0, img[9][5:0]}, {26'h0, gpio_oe});
      chk("pin levels", {26'h0, img[9][5:0] & img[10][5:0]}, {26'h0, gpio_out});
      gpio_in_i <= 6'($urandom);
      repeat (4) @(posedge clk_i);
      #1;
      chk("pin report", {26'h0, gpio_in_i & ~img[9][5:0]}, {26'h0, rpt});
      base = n_req;
      hpe <= 1'b1;
      repeat (6) @(posedge clk_i);
      #1;
      chk("host power search", 32'(base + (k % 2 == 0)), 32'(n_req));
      hpe <= 1'b0;
      repeat (24) @(posedge clk_i);
      #1;
      $display("test load %0d done", k);
    end
    stop_test();
  end
endmodule
`default_nettype wire

/* File: logic/cfg_loader_pkg.sv */
// Purpose: types shared by the config decoder
// Assumes: nothing
// Notes: state codes written out
package cfg_loader_pkg;

  typedef enum logic [2:0] {
    ST_WAIT_LOAD = 3'b000,
    ST_DELAY = 3'b001,
    ST_SEARCH = 3'b010,
    ST_WAIT_FOUND = 3'b011,
    ST_READY = 3'b100
  } boot_state_type;

  typedef struct packed {
    logic valid;
    logic write;
    logic [5:0] idx;
  } ahb_req_type;

  typedef struct packed {
    logic power_valid_en;
    logic bus_powered;
    logic unit0_removable;
    logic fast_dma_removable;
    logic search_on_host_power;
    logic unit0_use_drive_id;
    logic unit1_use_drive_id;
    logic [7:0] unit0_ptr;
    logic [7:0] unit1_ptr;
  } drive_cfg_type;

endpackage

/* File: logic/cfg_loader_regs.svh */
// Purpose: offsets, field positions, reset values and timing for the config decoder
// Assumes: register index times four is the byte address
// Notes: definitions only
`ifndef CFG_LOADER_REGS_SVH
`define CFG_LOADER_REGS_SVH

// ****************************************
// register indices
// ****************************************
`define IDX_OPTIONS 6'h08
`define IDX_GPIO_DIR 6'h09
`define IDX_GPIO_LVL 6'h0A
`define IDX_UNIT0_PTR 6'h0B
`define IDX_UNIT1_PTR 6'h0C
`define IDX_DELAY 6'h0D
`define IDX_DRIVE_OPT 6'h0E
`define IDX_RESERVED 6'h0F
`define IDX_DESC_LEN 6'h10
`define IDX_DESC_TYPE 6'h11
`define IDX_CONTROL 6'h18
`define IDX_STATUS 6'h19

// ****************************************
// field positions
// ****************************************
`define OPT_PWR_VALID_EN 0
`define GPIO_MSB 5
`define DRV_BUS_POWERED 4
`define DRV_FAST_DMA 3
`define DRV_LUN_HI 2
`define DRV_LUN_LO 1
`define DRV_SEARCH_SKIP 0
`define CTRL_LOAD 0

// ****************************************
// reset and expected values
// ****************************************
`define RST_BYTE 8'h00
`define RST_GPIO 6'h00
`define RST_DRV 5'h00
`define DESC_LEN_EXPECT 8'h12
`define DESC_TYPE_EXPECT 8'h01

// ****************************************
// timing
// ****************************************
`define TICK_MS 20
`define CLK_KHZ 100000

`endif

/* File: logic/pin_sync.sv */
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs are asynchronous to clk_i
// Notes: only the second stage leaves this module
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= pin_i;
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;

endmodule

`default_nettype wire

/* File: logic/storage_bridge_config_decoder.sv */
// Purpose: holds and decodes the bridge configuration bytes 0x08 to 0x11
// Assumes: the loader writes the image over AHB-Lite, then sets the load bit
// Notes: zero wait states; reads forward a write still in its data phase
//
// What this block does
// - byte 0x09 bits 5:0 set each general pin: 0 input, 1 driven output
// - levels of input-configured pins are sampled and reported to the host
// - output pins drive the level in byte 0x0A bits 5:0
// - byte 0x0B points to unit 0 name string; zero uses drive identify data
// - byte 0x0C points to unit 1 name string; zero uses drive identify data
// - wait byte 0x0D count of 20 ms ticks before first drive access
// - byte 0x0E bit 4 marks unit 0 bus-powered and non-removable
// - byte 0x0E bit 3 allows ultra DMA to removable devices
// - byte 0x0E bits 2:1 choose search, unit 0 only, or both units
// - byte 0x0E bit 0 clear searches on each host power enable rise seen in the ready state
// - byte 0x08 bit 0 enables drive power valid and removable master
//
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "cfg_loader_regs.svh"
`default_nettype none

module storage_bridge_config_decoder #(
  parameter int TICK_CYCLES = `TICK_MS * `CLK_KHZ
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic hsel_i,
  input wire logic [7:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic [5:0] gpio_in_i,
  output logic [5:0] gpio_out_o,
  output logic [5:0] gpio_oe_o,
  input wire logic host_power_drive_enable_i,
  input wire logic search_done_i,
  input wire logic [1:0] units_found_i,
  output logic [5:0] system_interrupt_report_o,
  output logic search_request_o,
  output logic drive_access_ok_o,
  output logic [1:0] units_present_o,
  output logic desc_ok_o,
  output cfg_loader_pkg::drive_cfg_type drive_cfg_o
);
  import cfg_loader_pkg::*;

  localparam int TICK_W = $clog2(TICK_CYCLES);

  // ****************************************
  // bus address phase
  // ****************************************
  ahb_req_type req_ff;
  ahb_req_type nxt_req;
  logic addr_ph;
  logic [5:0] rd_idx;

  // word transfers only, so hsize carries nothing this slave needs
  assign addr_ph = hsel_i & htrans_i[1] & hready_i;
  assign rd_idx = haddr_i[7:2];
  assign nxt_req = {addr_ph, hwrite_i, rd_idx};

  // ****************************************
  // write decode
  // ****************************************
  logic wr_en;
  logic [7:0] wbyte;
  logic wr_opt;
  logic wr_dir;
  logic wr_lvl;
  logic wr_ptr0;
  logic wr_ptr1;
  logic wr_delay;
  logic wr_drv;
  logic wr_len;
  logic wr_type;
  logic load;

  assign wr_en = req_ff.valid & req_ff.write;
  assign wbyte = hwdata_i[7:0];
  assign wr_opt = wr_en && (req_ff.idx == `IDX_OPTIONS);
  assign wr_dir = wr_en && (req_ff.idx == `IDX_GPIO_DIR);
  assign wr_lvl = wr_en && (req_ff.idx == `IDX_GPIO_LVL);
  assign wr_ptr0 = wr_en && (req_ff.idx == `IDX_UNIT0_PTR);
  assign wr_ptr1 = wr_en && (req_ff.idx == `IDX_UNIT1_PTR);
  assign wr_delay = wr_en && (req_ff.idx == `IDX_DELAY);
  assign wr_drv = wr_en && (req_ff.idx == `IDX_DRIVE_OPT);
  assign wr_len = wr_en && (req_ff.idx == `IDX_DESC_LEN);
  assign wr_type = wr_en && (req_ff.idx == `IDX_DESC_TYPE);
  assign load = wr_en && (req_ff.idx == `IDX_CONTROL) && hwdata_i[`CTRL_LOAD];

  // ****************************************
  // configuration image
  // ****************************************
  logic opt_ff;
  logic [5:0] dir_ff;
  logic [5:0] lvl_ff;
  logic [7:0] ptr0_ff;
  logic [7:0] ptr1_ff;
  logic [7:0] delay_ff;
  logic [4:0] drv_ff;
  logic [7:0] len_ff;
  logic [7:0] type_ff;
  logic nxt_opt;
  logic [5:0] nxt_dir;
  logic [5:0] nxt_lvl;
  logic [7:0] nxt_ptr0;
  logic [7:0] nxt_ptr1;
  logic [7:0] nxt_delay;
  logic [4:0] nxt_drv;
  logic [7:0] nxt_len;
  logic [7:0] nxt_type;

  // bits 7:1 of 0x08, 7:6 of 0x09 and 0x0A, and 7:5 of 0x0E are not stored and read back as zero
  assign nxt_opt = wr_opt ? wbyte[`OPT_PWR_VALID_EN] : opt_ff;
  assign nxt_dir = wr_dir ? wbyte[`GPIO_MSB:0] : dir_ff;
  assign nxt_lvl = wr_lvl ? wbyte[`GPIO_MSB:0] : lvl_ff;
  assign nxt_ptr0 = wr_ptr0 ? wbyte : ptr0_ff;
  assign nxt_ptr1 = wr_ptr1 ? wbyte : ptr1_ff;
  assign nxt_delay = wr_delay ? wbyte : delay_ff;
  assign nxt_drv = wr_drv ? wbyte[4:0] : drv_ff;
  assign nxt_len = wr_len ? wbyte : len_ff;
  assign nxt_type = wr_type ? wbyte : type_ff;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      req_ff <= '0;
      opt_ff <= 1'b0;
      dir_ff <= `RST_GPIO;
      lvl_ff <= `RST_GPIO;
      ptr0_ff <= `RST_BYTE;
      ptr1_ff <= `RST_BYTE;
      delay_ff <= `RST_BYTE;
      drv_ff <= `RST_DRV;
      len_ff <= `RST_BYTE;
      type_ff <= `RST_BYTE;
    end else begin
      req_ff <= nxt_req;
      opt_ff <= nxt_opt;
      dir_ff <= nxt_dir;
      lvl_ff <= nxt_lvl;
      ptr0_ff <= nxt_ptr0;
      ptr1_ff <= nxt_ptr1;
      delay_ff <= nxt_delay;
      drv_ff <= nxt_drv;
      len_ff <= nxt_len;
      type_ff <= nxt_type;
    end
  end

  // ****************************************
  // pin inputs
  // ****************************************
  logic [6:0] pins_sync;
  logic host_pwr;
  logic host_pwr_prev_ff;
  logic host_pwr_rise;

  pin_sync #(
    .WIDTH(7)
  ) u_pin_sync (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .pin_i({host_power_drive_enable_i, gpio_in_i}),
    .sync_o(pins_sync)
  );

  assign host_pwr = pins_sync[6];
  assign host_pwr_rise = host_pwr & ~host_pwr_prev_ff;

  // ****************************************
  // startup sequence
  // ****************************************
  boot_state_type state_ff;
  boot_state_type nxt_state;
  logic loaded_ff;
  logic [5:0] act_dir_ff;
  logic [5:0] act_lvl_ff;
  logic [7:0] act_ticks_ff;
  logic [1:0] act_lun_ff;
  logic act_skip_ff;
  logic [TICK_W-1:0] tick_cnt_ff;
  logic [7:0] tick_num_ff;
  logic tick_end;
  logic delay_over;
  logic [1:0] fixed_units;
  logic [1:0] units_ff;

  assign tick_end = (tick_cnt_ff == TICK_W'(TICK_CYCLES - 1));
  assign delay_over = (tick_num_ff == act_ticks_ff);
  // 01 names unit 0 only, 10 and 11 both units
  assign fixed_units = act_lun_ff[1] ? 2'b11 : 2'b01;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_WAIT_LOAD: begin
        nxt_state = ST_WAIT_LOAD;
      end
      ST_DELAY: begin
        if (delay_over) begin
          if (act_lun_ff == 2'b00) begin
            nxt_state = ST_SEARCH;
          end else begin
            nxt_state = ST_READY;
          end
        end
      end
      ST_SEARCH: begin
        nxt_state = ST_WAIT_FOUND;
      end
      ST_WAIT_FOUND: begin
        if (search_done_i) begin
          nxt_state = ST_READY;
        end
      end
      ST_READY: begin
        // the encoding wins over the prose: a clear bit searches
        if (host_pwr_rise && !act_skip_ff) begin
          nxt_state = ST_SEARCH;
        end
      end
      default: begin
        nxt_state = ST_WAIT_LOAD;
      end
    endcase
    // a fresh load restarts the whole sequence, delay included
    if (load) begin
      nxt_state = ST_DELAY;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_ff <= ST_WAIT_LOAD;
      host_pwr_prev_ff <= 1'b0;
      tick_cnt_ff <= '0;
      tick_num_ff <= `RST_BYTE;
    end else begin
      state_ff <= nxt_state;
      host_pwr_prev_ff <= host_pwr;
      if (load || state_ff != ST_DELAY || delay_over) begin
        tick_cnt_ff <= '0;
        tick_num_ff <= `RST_BYTE;
      end else if (tick_end) begin
        tick_cnt_ff <= '0;
        tick_num_ff <= tick_num_ff + 8'h01;
      end else begin
        tick_cnt_ff <= tick_cnt_ff + TICK_W'(1);
      end
    end
  end

  // ****************************************
  // latched image applied to the pins
  // ****************************************
  // outputs follow the latched copy so partial loads never reach the pins
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      loaded_ff <= 1'b0;
      act_dir_ff <= `RST_GPIO;
      act_lvl_ff <= `RST_GPIO;
      act_ticks_ff <= `RST_BYTE;
      act_lun_ff <= 2'b00;
      act_skip_ff <= 1'b0;
      drive_cfg_o <= '0;
    end else if (load) begin
      loaded_ff <= 1'b1;
      act_dir_ff <= dir_ff;
      act_lvl_ff <= lvl_ff;
      act_ticks_ff <= delay_ff;
      act_lun_ff <= drv_ff[`DRV_LUN_HI:`DRV_LUN_LO];
      act_skip_ff <= drv_ff[`DRV_SEARCH_SKIP];
      drive_cfg_o.power_valid_en <= opt_ff;
      drive_cfg_o.bus_powered <= drv_ff[`DRV_BUS_POWERED];
      drive_cfg_o.unit0_removable <= opt_ff & ~drv_ff[`DRV_BUS_POWERED];
      drive_cfg_o.fast_dma_removable <= drv_ff[`DRV_FAST_DMA];
      drive_cfg_o.search_on_host_power <= ~drv_ff[`DRV_SEARCH_SKIP];
      drive_cfg_o.unit0_use_drive_id <= (ptr0_ff == `RST_BYTE);
      drive_cfg_o.unit1_use_drive_id <= (ptr1_ff == `RST_BYTE);
      drive_cfg_o.unit0_ptr <= ptr0_ff;
      drive_cfg_o.unit1_ptr <= ptr1_ff;
    end
  end

  // ****************************************
  // drive side outputs
  // ****************************************
  logic [5:0] nxt_report;
  logic [1:0] nxt_units;

  assign nxt_report = pins_sync[5:0] & ~act_dir_ff;
  assign nxt_units = (state_ff == ST_WAIT_FOUND && search_done_i) ? units_found_i
                   : (state_ff == ST_DELAY && delay_over && act_lun_ff != 2'b00)
                   ? fixed_units : units_ff;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gpio_oe_o <= `RST_GPIO;
      gpio_out_o <= `RST_GPIO;
      system_interrupt_report_o <= `RST_GPIO;
      search_request_o <= 1'b0;
      drive_access_ok_o <= 1'b0;
      units_ff <= 2'b00;
      desc_ok_o <= 1'b0;
    end else begin
      gpio_oe_o <= loaded_ff ? act_dir_ff : `RST_GPIO;
      gpio_out_o <= loaded_ff ? (act_lvl_ff & act_dir_ff) : `RST_GPIO;
      system_interrupt_report_o <= nxt_report;
      search_request_o <= (nxt_state == ST_SEARCH);
      drive_access_ok_o <= (nxt_state != ST_WAIT_LOAD) && (nxt_state != ST_DELAY);
      units_ff <= load ? 2'b00 : nxt_units;
      desc_ok_o <= (len_ff == `DESC_LEN_EXPECT) && (type_ff == `DESC_TYPE_EXPECT);
    end
  end

  assign units_present_o = units_ff;

  // ****************************************
  // read path
  // ****************************************
  logic [31:0] status_word;
  logic [31:0] rd_word;

  assign status_word = {16'h0000, 2'b00, system_interrupt_report_o, desc_ok_o,
                        loaded_ff, units_ff, 1'b0, state_ff};

  // reads pick the next values so a write in its data phase is seen
  assign rd_word =
      (rd_idx == `IDX_OPTIONS) ? {31'h00000000, nxt_opt}
    : (rd_idx == `IDX_GPIO_DIR) ? {26'h0000000, nxt_dir}
    : (rd_idx == `IDX_GPIO_LVL) ? {26'h0000000, nxt_lvl}
    : (rd_idx == `IDX_UNIT0_PTR) ? {24'h000000, nxt_ptr0}
    : (rd_idx == `IDX_UNIT1_PTR) ? {24'h000000, nxt_ptr1}
    : (rd_idx == `IDX_DELAY) ? {24'h000000, nxt_delay}
    : (rd_idx == `IDX_DRIVE_OPT) ? {27'h0000000, nxt_drv}
    : (rd_idx == `IDX_DESC_LEN) ? {24'h000000, nxt_len}
    : (rd_idx == `IDX_DESC_TYPE) ? {24'h000000, nxt_type}
    : (rd_idx == `IDX_STATUS) ? status_word
    : 32'h00000000;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hrdata_o <= 32'h00000000;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end else begin
      hrdata_o <= (addr_ph && !hwrite_i) ? rd_word : 32'h00000000;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end
  end

endmodule

`default_nettype wire
